// ===== adc_conversion_control.sv
`timescale 1ns/10ps
`include "adc_conv_defs.svh"

module adc_conversion_control #(
	parameter int ADDR_W = 12
) (
	input  wire logic                        core_clk,
	input  wire logic                        rst_n,
	input  wire logic                        hsel,
	input  wire logic [ADDR_W-1:0]           haddr,
	input  wire logic [1:0]                  htrans,
	input  wire logic                        hwrite,
	input  wire logic [2:0]                  hsize,
	input  wire logic [31:0]                 hwdata,
	input  wire logic                        hready,
	output logic                             hreadyout,
	output logic                             hresp,
	output logic [31:0]                      hrdata,
	input  wire logic                        doubleSpeed,
	input  wire adc_conv_pkg::analog_level_t converterInput,
	output logic [2:0]                       inputChannelSelect,
	output logic [7:0]                       pinAnalogAssign,
	output logic                             converterPowerEnable,
	output logic                             quietConvertHold,
	output logic                             irq
);
	import adc_conv_pkg::*;

	// ****************************************************************
	// Helper functions.
	// ****************************************************************
	function automatic logic [6:0] divLast(input logic [4:0] scale, input logic fast);
		logic [6:0] d;
		d = fast ? {1'b0, scale, 1'b0} : {scale, 2'b00};
		if (scale == 5'h00) begin
			d = `ADC_DIV_ZERO;
		end
		return 7'(d - 7'h01);
	endfunction

	function automatic logic [9:0] saturate(input analog_level_t v);
		logic [9:0] r;
		r = v[9:0];
		if (v < 12'sh000) begin
			r = `ADC_ZERO_CODE;
		end else if (v > 12'sh3ff) begin
			r = `ADC_FULL_SCALE;
		end
		return r;
	endfunction

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	conv_state_t state_q;
	logic                apValid_q;
	logic                apWrite_q;
	logic [ADDR_W-3:0]   apIndex_q;
	logic [7:0]          wrByte;
	logic                wrCtrl;
	logic                wrClr;
	logic                startReq;
	logic                accept;
	logic                refused;
	logic                busy;
	logic                tick;
	logic                lastStep;
	logic [6:0]          tickCnt_q;
	logic [4:0]          clkDiv_q;
	logic [7:0]          pinCfg_q;
	logic [2:0]          chanSel_q;
	logic                powerEn_q;
	logic                quietSel_q;
	logic                quietRun_q;
	logic                doneFlag_q;
	logic                refusedFlag_q;
	logic [1:0]          irqEnable_q;
	logic [1:0]          irqStatus;
	logic [2:0]          convChan_q;
	logic [9:0]          held_q;
	logic [9:0]          sar_q;
	logic [9:0]          sar_d;
	logic [9:0]          trial;
	logic [3:0]          bitPos_q;
	logic [9:0]          result_q;
	logic [7:0]          ctrlRead;
	logic [7:0]          readByte;
	logic [ADDR_W-3:0]   rdIndex;

	// ****************************************************************
	// Bus slave: zero wait states, always OKAY.
	// ****************************************************************
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			apValid_q <= 1'b0;
			apWrite_q <= 1'b0;
			apIndex_q <= '0;
		end else if (hready) begin
			apValid_q <= hsel & htrans[1];
			apWrite_q <= hwrite;
			apIndex_q <= haddr[ADDR_W-1:2];
		end
	end

	assign wrByte = hwdata[7:0];
	assign wrCtrl = apValid_q & apWrite_q & (apIndex_q == `ADC_IDX_CTRL);
	assign wrClr  = apValid_q & apWrite_q & (apIndex_q == `ADC_IDX_IRQ_CLR);
	assign rdIndex = haddr[ADDR_W-1:2];

	// Reads are sampled in the address phase so the data phase needs no wait.
	always_comb begin
		unique case (rdIndex)
			`ADC_IDX_CLKDIV:   readByte = {3'b000, clkDiv_q};
			`ADC_IDX_CTRL:     readByte = ctrlRead;
			`ADC_IDX_RES_LO:   readByte = {6'b000000, result_q[1:0]};
			`ADC_IDX_RES_HI:   readByte = result_q[9:2];
			`ADC_IDX_PINCFG:   readByte = pinCfg_q;
			`ADC_IDX_IRQ_STAT: readByte = {6'b000000, irqStatus};
			`ADC_IDX_IRQ_EN:   readByte = {6'b000000, irqEnable_q};
			default:           readByte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			hrdata <= 32'h00000000;
		end else if (hready & hsel & htrans[1] & !hwrite) begin
			hrdata <= {24'h000000, readByte};
		end
	end

	// ****************************************************************
	// Configuration registers.
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			clkDiv_q <= `ADC_RST_CLKDIV;
		end else if (apValid_q & apWrite_q & (apIndex_q == `ADC_IDX_CLKDIV)) begin
			clkDiv_q <= wrByte[4:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pinCfg_q <= `ADC_RST_PINCFG;
		end else if (apValid_q & apWrite_q & (apIndex_q == `ADC_IDX_PINCFG)) begin
			pinCfg_q <= wrByte;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irqEnable_q <= `ADC_RST_IRQ;
		end else if (apValid_q & apWrite_q & (apIndex_q == `ADC_IDX_IRQ_EN)) begin
			irqEnable_q <= wrByte[1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			quietSel_q <= 1'b0;
			powerEn_q  <= 1'b0;
			chanSel_q  <= 3'b000;
		end else if (wrCtrl) begin
			quietSel_q <= wrByte[`ADC_CTRL_QUIET];
			powerEn_q  <= wrByte[`ADC_CTRL_POWER];
			chanSel_q  <= wrByte[`ADC_CTRL_CH_HI:`ADC_CTRL_CH_LO];
		end
	end

	assign busy = (state_q != CONV_IDLE);
	assign ctrlRead = {1'b0, quietSel_q, powerEn_q, doneFlag_q, busy, chanSel_q};

	// ****************************************************************
	// Start decision.
	// ****************************************************************
	// The written values count, so one write may enable, select and start.
	assign startReq = wrCtrl & wrByte[`ADC_CTRL_START];
	assign accept = startReq & !busy
		& wrByte[`ADC_CTRL_POWER]
		& pinCfg_q[wrByte[`ADC_CTRL_CH_HI:`ADC_CTRL_CH_LO]];
	assign refused = startReq & !accept;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			convChan_q <= 3'b000;
			quietRun_q <= 1'b0;
		end else if (accept) begin
			convChan_q <= wrByte[`ADC_CTRL_CH_HI:`ADC_CTRL_CH_LO];
			quietRun_q <= wrByte[`ADC_CTRL_QUIET];
		end
	end

	// ****************************************************************
	// Converter clock prescaler.
	// ****************************************************************
	// The divider restarts with each conversion so every step is a full period.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tickCnt_q <= 7'h00;
		end else if (accept || tick || !busy) begin
			tickCnt_q <= 7'h00;
		end else begin
			tickCnt_q <= 7'(tickCnt_q + 7'h01);
		end
	end

	assign tick = busy & (tickCnt_q == divLast(clkDiv_q, doubleSpeed));

	// ****************************************************************
	// Conversion sequence.
	// ****************************************************************
	assign trial    = 10'(sar_q | (10'h001 << bitPos_q));
	assign sar_d    = (held_q >= trial) ? trial : sar_q;
	assign lastStep = (state_q == CONV_RESOLVE) & tick & (bitPos_q == 4'h0);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_q <= CONV_IDLE;
		end else begin
			unique case (state_q)
				CONV_IDLE: begin
					if (accept) begin
						state_q <= CONV_SAMPLE;
					end
				end
				CONV_SAMPLE: begin
					if (tick) begin
						state_q <= CONV_RESOLVE;
					end
				end
				CONV_RESOLVE: begin
					if (lastStep) begin
						state_q <= CONV_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			held_q   <= 10'h000;
			sar_q    <= 10'h000;
			bitPos_q <= 4'h0;
		end else if (state_q == CONV_SAMPLE && tick) begin
			held_q   <= saturate(converterInput);
			sar_q    <= 10'h000;
			bitPos_q <= `ADC_TOP_BIT;
		end else if (state_q == CONV_RESOLVE && tick) begin
			sar_q    <= sar_d;
			bitPos_q <= 4'(bitPos_q - 4'h1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result_q <= `ADC_RST_RESULT;
		end else if (lastStep) begin
			result_q <= sar_d;
		end
	end

	// ****************************************************************
	// Flags and interrupt.
	// ****************************************************************
	// A completion in the same cycle as a clear keeps the flag set.
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			doneFlag_q <= 1'b0;
		end else if (lastStep) begin
			doneFlag_q <= 1'b1;
		end else if ((wrCtrl && !wrByte[`ADC_CTRL_DONE]) || (wrClr && wrByte[`ADC_IRQ_DONE])) begin
			doneFlag_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			refusedFlag_q <= 1'b0;
		end else if (refused) begin
			refusedFlag_q <= 1'b1;
		end else if (wrClr && wrByte[`ADC_IRQ_REFUSED]) begin
			refusedFlag_q <= 1'b0;
		end
	end

	assign irqStatus = {doneFlag_q, refusedFlag_q};
	assign irq = |(irqStatus & irqEnable_q);

	// ****************************************************************
	// Pin side outputs.
	// ****************************************************************
	assign inputChannelSelect   = convChan_q;
	assign pinAnalogAssign      = pinCfg_q;
	assign converterPowerEnable = powerEn_q;
	// The interrupt controller defers other sources while this is high.
	assign quietConvertHold     = quietRun_q & busy;

endmodule

// ===== adc_conv_defs.svh
`ifndef ADC_CONV_DEFS_SVH
`define ADC_CONV_DEFS_SVH

// ********************************************************************
// Register indices; byte address is four times the index.
// ********************************************************************
`define ADC_IDX_CLKDIV   10'h0f2
`define ADC_IDX_CTRL     10'h0f3
`define ADC_IDX_RES_LO   10'h0f4
`define ADC_IDX_RES_HI   10'h0f5
`define ADC_IDX_PINCFG   10'h0f6
`define ADC_IDX_IRQ_STAT 10'h0f7
`define ADC_IDX_IRQ_EN   10'h0f8
`define ADC_IDX_IRQ_CLR  10'h0f9

// ********************************************************************
// Control register fields.
// ********************************************************************
`define ADC_CTRL_QUIET   6
`define ADC_CTRL_POWER   5
`define ADC_CTRL_DONE    4
`define ADC_CTRL_START   3
`define ADC_CTRL_CH_HI   2
`define ADC_CTRL_CH_LO   0

// ********************************************************************
// Interrupt status, enable and clear fields.
// ********************************************************************
`define ADC_IRQ_REFUSED  0
`define ADC_IRQ_DONE     1

// ********************************************************************
// Reset values.
// ********************************************************************
`define ADC_RST_CTRL     8'h00
`define ADC_RST_CLKDIV   5'h00
`define ADC_RST_PINCFG   8'h00
`define ADC_RST_RESULT   10'h000
`define ADC_RST_IRQ      2'h0

// ********************************************************************
// Timing and coding constants.
// ********************************************************************
`define ADC_DIV_ZERO     7'h40
`define ADC_TOP_BIT      4'h9
`define ADC_FULL_SCALE   10'h3ff
`define ADC_ZERO_CODE    10'h000

`endif

// ===== adc_conv_pkg.sv
package adc_conv_pkg;

	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_SAMPLE,
		CONV_RESOLVE
	} conv_state_t;

	typedef logic signed [11:0] analog_level_t;

endpackage

// ===== adc_conversion_control_props.sv
`timescale 1ns/10ps
// ********************************************************************
// Port checks of the converter control block.
// ********************************************************************
module adc_conversion_control_props (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hrdata,
	input wire logic [2:0]  inputChannelSelect,
	input wire logic [7:0]  pinAnalogAssign,
	input wire logic        converterPowerEnable,
	input wire logic        quietConvertHold,
	input wire logic        irq
);
	logic wrA;
	logic rdA;
	assign wrA = hsel && htrans[1] && hwrite;
	assign rdA = hsel && htrans[1] && !hwrite;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// Only a bus write can take the interrupt down; hardware never clears it.
	property p_irqFall; $fell(irq) |-> $past(wrA, 2); endproperty
	property p_quietStart; $rose(quietConvertHold) |-> $past(wrA, 2); endproperty
	property p_quietLen; $rose(quietConvertHold) |-> quietConvertHold [*8]; endproperty
	property p_pin; !$stable(pinAnalogAssign) |-> $past(wrA, 2); endproperty
	property p_power; !$stable(converterPowerEnable) |-> $past(wrA, 2); endproperty
	property p_chan; !$stable(inputChannelSelect) |-> $past(wrA, 2); endproperty
	property p_rdHigh; hrdata[31:8] == 24'h0; endproperty
	property p_rdHold; !$stable(hrdata) |-> $past(rdA); endproperty
	a_irqFall: assert property (p_irqFall) else $error("irq fell without a write");
	a_quietStart: assert property (p_quietStart) else $error("quiet without start");
	a_quietLen: assert property (p_quietLen) else $error("conversion too short");
	a_pin: assert property (p_pin) else $error("pin config changed alone");
	a_power: assert property (p_power) else $error("power changed alone");
	a_chan: assert property (p_chan) else $error("channel changed alone");
	a_rdHigh: assert property (p_rdHigh) else $error("read data upper bits set");
	a_rdHold: assert property (p_rdHold) else $error("read data changed alone");
	c_irq: cover property ($rose(irq));
	c_quiet: cover property ($rose(quietConvertHold));
	c_pin: cover property (!$stable(pinAnalogAssign));
endmodule

bind adc_conversion_control adc_conversion_control_props i_props (.core_clk, .rst_n, .hsel,
	.htrans, .hwrite, .hrdata, .inputChannelSelect, .pinAnalogAssign, .converterPowerEnable,
	.quietConvertHold, .irq);

// ===== analog_source_model.sv
`timescale 1ns/10ps
// ********************************************************************
// Eight analog inputs behind the channel multiplexer.
// ********************************************************************
module analog_source_model
	import adc_conv_pkg::*;
(
	input  wire logic [2:0]             inputChannelSelect,
	output adc_conv_pkg::analog_level_t converterInput
);
	// Levels reach both references and lie beyond them, to show saturation.
	localparam analog_level_t LVL [8] = '{12'sh000, 12'sh3ff, -12'sh005, 12'sh7d0,
		12'sh200, 12'sh155, 12'sh001, 12'sh3fe};
	assign converterInput = LVL[inputChannelSelect];
endmodule

// ===== adc_conversion_control_bench.sv
`timescale 1ns/10ps
`include "adc_conv_defs.svh"
`define CHK(g, w) begin compares++; if ((g) !== (w)) begin n_errors++; \
	$display("unexpected at %0t: got %0h want %0h", $time, g, w); end end
// ********************************************************************
// Self-checking bench.
// ********************************************************************
module adc_conversion_control_bench;
	import adc_conv_pkg::*;
	logic          core_clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          hsel = 1'b0;
	logic          hwrite = 1'b0;
	logic          doubleSpeed = 1'b0;
	logic [11:0]   haddr = 12'h000;
	logic [1:0]    htrans = 2'h0;
	logic [2:0]    hsize = 3'h2;
	logic [31:0]   hwdata = 32'h0;
	logic [31:0]   hrdata;
	logic          hreadyout, hresp, converterPowerEnable, quietConvertHold, irq;
	logic [2:0]    inputChannelSelect;
	logic [7:0]    pinAnalogAssign;
	analog_level_t converterInput;
	int            n_errors = 0;
	int            compares = 0;
	int            cycles = 0;
	localparam logic [9:0] EXP [8] = '{10'h000, 10'h3ff, 10'h000, 10'h3ff,
		10'h200, 10'h155, 10'h001, 10'h3fe};

	adc_conversion_control i_adc_conversion_control (.core_clk, .rst_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .doubleSpeed,
		.converterInput, .inputChannelSelect, .pinAnalogAssign, .converterPowerEnable,
		.quietConvertHold, .irq);
	analog_source_model i_analog_source_model (.inputChannelSelect, .converterInput);

	initial begin
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic busOp(input logic w, input logic [9:0] idx, input logic [7:0] d,
		output logic [7:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {idx, 2'h0};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		r = hrdata[7:0];
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic [7:0] r;
		busOp(1'b1, idx, d, r);
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] want);
		logic [7:0] r;
		busOp(1'b0, idx, 8'h00, r);
		`CHK(r, want)
	endtask
	task automatic waitIrq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			n++;
		end
	endtask

	task automatic regsReset();
		rd(`ADC_IDX_CTRL, 8'h00);
		rd(`ADC_IDX_RES_LO, 8'h00);
		rd(10'h3ff, 8'h00);
		wr(`ADC_IDX_RES_HI, 8'hff);
		rd(`ADC_IDX_RES_HI, 8'h00);
	endtask
	task automatic convertAll();
		logic [7:0] hi, lo;
		int n, d;
		wr(`ADC_IDX_PINCFG, 8'hff);
		wr(`ADC_IDX_IRQ_EN, 8'h02);
		wr(`ADC_IDX_CTRL, 8'h20);
		repeat (20) @(posedge core_clk);
		`CHK(pinAnalogAssign, 8'hff)
		`CHK(converterPowerEnable, 1'b1)
		for (int ch = 0; ch < 8; ch++) begin
			doubleSpeed <= ch[0] & ch[1];
			d = (ch == 0) ? 64 : ((ch[0] & ch[1]) ? 2 : 4) * ch;
			wr(`ADC_IDX_CLKDIV, 8'(ch));
			wr(`ADC_IDX_CTRL, 8'h28 | 8'(ch));
			waitIrq(n);
			`CHK(n, 11 * d + 1)
			`CHK(inputChannelSelect, 3'(ch))
			rd(`ADC_IDX_CTRL, 8'h30 | 8'(ch));
			busOp(1'b0, `ADC_IDX_RES_HI, 8'h00, hi);
			busOp(1'b0, `ADC_IDX_RES_LO, 8'h00, lo);
			`CHK({hi, lo}, {EXP[ch][9:2], 6'h0, EXP[ch][1:0]})
			wr(`ADC_IDX_CTRL, 8'h20);
			@(posedge core_clk);
			`CHK(irq, 1'b0)
		end
		doubleSpeed <= 1'b0;
	endtask
	task automatic refusals();
		wr(`ADC_IDX_IRQ_EN, 8'h03);
		wr(`ADC_IDX_PINCFG, 8'hfe);
		wr(`ADC_IDX_CTRL, 8'h28);
		rd(`ADC_IDX_CTRL, 8'h20);
		rd(`ADC_IDX_IRQ_STAT, 8'h01);
		`CHK(irq, 1'b1)
		wr(`ADC_IDX_IRQ_EN, 8'h02);
		rd(`ADC_IDX_IRQ_EN, 8'h02);
		`CHK(irq, 1'b0)
		wr(`ADC_IDX_IRQ_CLR, 8'h01);
		wr(`ADC_IDX_CTRL, 8'h09);
		rd(`ADC_IDX_IRQ_STAT, 8'h01);
		wr(`ADC_IDX_IRQ_CLR, 8'h01);
		wr(`ADC_IDX_CTRL, 8'h29);
		wr(`ADC_IDX_CTRL, 8'h2a);
		rd(`ADC_IDX_CTRL, 8'h2a);
		rd(`ADC_IDX_IRQ_STAT, 8'h01);
		`CHK(inputChannelSelect, 3'h1)
		while (irq !== 1'b1 || cycles < 0) @(posedge core_clk);
		rd(`ADC_IDX_RES_HI, 8'hff);
		wr(`ADC_IDX_CTRL, 8'h20);
		wr(`ADC_IDX_IRQ_CLR, 8'h03);
	endtask
	task automatic quietConv();
		int n;
		wr(`ADC_IDX_CTRL, 8'h6c);
		@(posedge core_clk);
		`CHK(quietConvertHold, 1'b1)
		waitIrq(n);
		`CHK(n, 11 * 28)
		`CHK(quietConvertHold, 1'b0)
		rd(`ADC_IDX_RES_HI, 8'h80);
		wr(`ADC_IDX_IRQ_CLR, 8'h02);
		rd(`ADC_IDX_IRQ_STAT, 8'h00);
		`CHK(irq, 1'b0)
		wr(`ADC_IDX_CTRL, 8'h00);
		@(posedge core_clk);
		`CHK(converterPowerEnable, 1'b0)
	endtask
	task automatic summarize();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		regsReset();
		convertAll();
		refusals();
		quietConv();
		summarize();
	end
endmodule
